// ### logic/flc_defs.vh
/*
  Constants of the lock-bit flash controller: register offsets, control bits,
  flash command codes, status byte fields and timing figures.
  Assumes inclusion by bare name from the design file.
*/
`ifndef FLC_DEFS_VH
`define FLC_DEFS_VH

// ****************************************
// Clock and timing figures
// ****************************************
`define FLC_CLK_NS        5
`define FLC_T_SETUP_NS    10
`define FLC_T_WP_NS       60
`define FLC_T_HOLD_NS     10
`define FLC_T_READ_NS     100
`define FLC_T_RST_NS      100
`define FLC_T_WAKE_NS     1000
`define FLC_CYC(ns)       (((ns) + `FLC_CLK_NS - 1) / `FLC_CLK_NS)

// ****************************************
// Register offsets
// ****************************************
`define FLC_REG_CTRL      12'h000
`define FLC_REG_BLOCK     12'h004
`define FLC_REG_STAT      12'h008

// ****************************************
// Control register bits
// ****************************************
`define FLC_CTRL_SET      0
`define FLC_CTRL_CLEAR    1
`define FLC_CTRL_CLRSTAT  2
`define FLC_CTRL_RDARRAY  3
`define FLC_CTRL_RESET    4

// ****************************************
// Status register bits
// ****************************************
`define FLC_STAT_BUSY     0
`define FLC_STAT_ABORT    1
`define FLC_STAT_PIN      2
`define FLC_STAT_SEQERR   3
`define FLC_STAT_SETERR   4
`define FLC_STAT_CLRERR   5
`define FLC_STAT_SUPPLY   6
`define FLC_STAT_PROTECT  7
`define FLC_STAT_BYTE_LO  8

// ****************************************
// Flash command codes and status byte fields
// ****************************************
`define FLC_CMD_LOCK_SETUP 8'h60
`define FLC_CMD_SET_CONF   8'h01
`define FLC_CMD_CLR_CONF   8'hd0
`define FLC_CMD_CLR_STATUS 8'h50
`define FLC_CMD_READ_ARRAY 8'hff
`define FLC_SR_READY       7
`define FLC_SR_CLR_ERR     5
`define FLC_SR_SET_ERR     4
`define FLC_SR_SUPPLY_ERR  3
`define FLC_SR_PROTECT     1

// ****************************************
// Operations and step kinds
// ****************************************
`define FLC_OP_SET        2'h0
`define FLC_OP_CLEAR      2'h1
`define FLC_OP_CLRSTAT    2'h2
`define FLC_OP_RDARRAY    2'h3
`define FLC_KIND_WRITE    2'h0
`define FLC_KIND_POLL     2'h1
`define FLC_KIND_DONE     2'h2

`endif

// ### logic/flc_ctrl.v
/*
  Host-side controller that drives an asynchronous flash through its pins to
  set and clear block lock-bits, clear status, return to read array and pulse
  reset/deep power-down; software orders it over an APB slave.
  Assumes all flash inputs are synchronous to pclk and the data bus wire is
  resolved outside from the output enable.
*/
// Added by the designer: the placing of the registers and the APB register port.
// Contract
// - Poll ready bit until machine is ready
// - Host writes FFH after clearing lock-bits
// - Host reissues sequence after reset abort; the controller only flags ABORT and leaves reissue to software
// - Host writes read array after configuration
// - Host waits wake time after reset release
`timescale 1ns/1ps
`include "flc_defs.vh"

module flc_ctrl #(
  parameter AW        = 21,                      // Flash address width
  parameter T_SETUP_NS = `FLC_T_SETUP_NS,        // Address/data setup before write strobe
  parameter T_WP_NS   = `FLC_T_WP_NS,            // Write strobe low time
  parameter T_HOLD_NS = `FLC_T_HOLD_NS,          // Hold after write strobe
  parameter T_READ_NS = `FLC_T_READ_NS,          // Output enable to data valid
  parameter T_RST_NS  = `FLC_T_RST_NS,           // Reset low time
  parameter T_WAKE_NS = `FLC_T_WAKE_NS           // Wake-up after reset release
) (
  input  wire          pclk,                     // Clock
  input  wire          presetn,                  // Async reset, active low
  input  wire          psel,                     // APB select
  input  wire          penable,                  // APB enable
  input  wire          pwrite,                   // APB direction
  input  wire [11:0]   paddr,                    // APB address
  input  wire [31:0]   pwdata,                   // APB write data
  output reg  [31:0]   prdata,                   // APB read data
  output reg           pready,                   // APB ready
  output reg           pslverr,                  // APB error
  output reg  [AW-1:0] flash_addr,               // Flash address
  output reg  [7:0]    flash_dq_o,               // Flash data out
  output reg           flash_dq_oe,              // Flash data drive enable
  input  wire [7:0]    flash_dq_i,               // Flash data in
  output reg           flash_we_n,               // Flash write enable
  output reg           flash_oe_n,               // Flash output enable
  output reg           bank_enable_n,            // Flash bank enable
  output reg           reset_powerdown_n,        // Flash reset/deep power-down
  input  wire          completion_output         // Flash completion pin level
);

  // ****************************************
  // Timing counts
  // ****************************************
  localparam [15:0] SETUP_CYC = `FLC_CYC(T_SETUP_NS);
  localparam [15:0] WP_CYC    = `FLC_CYC(T_WP_NS);
  localparam [15:0] HOLD_CYC  = `FLC_CYC(T_HOLD_NS);
  localparam [15:0] READ_CYC  = `FLC_CYC(T_READ_NS);
  localparam [15:0] RST_CYC   = `FLC_CYC(T_RST_NS);
  localparam [15:0] WAKE_CYC  = `FLC_CYC(T_WAKE_NS);

  // ****************************************
  // States
  // ****************************************
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_SETUP = 8'h02;
  localparam [7:0] S_PULSE = 8'h04;
  localparam [7:0] S_HOLD  = 8'h08;
  localparam [7:0] S_READ  = 8'h10;
  localparam [7:0] S_CHECK = 8'h20;
  localparam [7:0] S_RST   = 8'h40;
  localparam [7:0] S_WAKE  = 8'h80;

  // Step plan of each operation: {kind, byte}
  function [9:0] plan;
    input [1:0] op;
    input [2:0] step;
    begin
      plan = {`FLC_KIND_DONE, 8'h00};
      case (op)
        `FLC_OP_SET, `FLC_OP_CLEAR: begin
          case (step)
            3'h0: plan = {`FLC_KIND_WRITE, `FLC_CMD_LOCK_SETUP};
            3'h1: plan = {`FLC_KIND_WRITE, (op == `FLC_OP_SET) ? `FLC_CMD_SET_CONF : `FLC_CMD_CLR_CONF};
            3'h2: plan = {`FLC_KIND_POLL, 8'h00};
            3'h3: plan = {`FLC_KIND_WRITE, `FLC_CMD_READ_ARRAY};
            default: plan = {`FLC_KIND_DONE, 8'h00};
          endcase
        end
        `FLC_OP_CLRSTAT: begin
          if (step == 3'h0) begin
            plan = {`FLC_KIND_WRITE, `FLC_CMD_CLR_STATUS};
          end
        end
        default: begin
          if (step == 3'h0) begin
            plan = {`FLC_KIND_WRITE, `FLC_CMD_READ_ARRAY};
          end
        end
      endcase
    end
  endfunction

  reg  [7:0]    state_q;
  reg  [15:0]   cnt_q;
  reg  [1:0]    op_q;
  reg  [2:0]    step_q;
  reg  [AW-1:0] block_q;
  reg  [7:0]    sr_q;
  reg           abort_q;
  reg           pin_q;

  wire          acc      = psel & penable & ~pready;
  wire          wr_ctrl  = acc & pwrite & (paddr == `FLC_REG_CTRL);
  wire          busy     = (state_q != S_IDLE);
  wire          go_rst   = wr_ctrl & pwdata[`FLC_CTRL_RESET];
  wire          go_op    = wr_ctrl & ~busy & (|pwdata[`FLC_CTRL_RDARRAY:`FLC_CTRL_SET]);
  wire [9:0]    cur_plan = plan(op_q, step_q);
  wire          cnt_done = (cnt_q == 16'h0001);
  wire          clr_abort = acc & pwrite & (paddr == `FLC_REG_STAT) & pwdata[`FLC_STAT_ABORT];
  reg  [1:0]    go_code;

  always @* begin
    go_code = `FLC_OP_RDARRAY;
    if (pwdata[`FLC_CTRL_SET]) begin
      go_code = `FLC_OP_SET;
    end else if (pwdata[`FLC_CTRL_CLEAR]) begin
      go_code = `FLC_OP_CLEAR;
    end else if (pwdata[`FLC_CTRL_CLRSTAT]) begin
      go_code = `FLC_OP_CLRSTAT;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      block_q <= {AW{1'b0}};
    end else begin
      pready  <= acc;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (acc) begin
        if (paddr == `FLC_REG_CTRL) begin
          pslverr <= pwrite & busy & ~pwdata[`FLC_CTRL_RESET] & (|pwdata[`FLC_CTRL_RDARRAY:`FLC_CTRL_SET]);
        end else if (paddr == `FLC_REG_BLOCK) begin
          if (pwrite) begin
            block_q <= pwdata[AW-1:0];
          end else begin
            prdata[AW-1:0] <= block_q;
          end
        end else if (paddr == `FLC_REG_STAT) begin
          if (!pwrite) begin
            prdata[`FLC_STAT_BUSY]    <= busy;
            prdata[`FLC_STAT_ABORT]   <= abort_q;
            prdata[`FLC_STAT_PIN]     <= pin_q;
            prdata[`FLC_STAT_SEQERR]  <= sr_q[`FLC_SR_SET_ERR] & sr_q[`FLC_SR_CLR_ERR];
            prdata[`FLC_STAT_SETERR]  <= sr_q[`FLC_SR_SET_ERR] & ~sr_q[`FLC_SR_CLR_ERR];
            prdata[`FLC_STAT_CLRERR]  <= sr_q[`FLC_SR_CLR_ERR] & ~sr_q[`FLC_SR_SET_ERR];
            prdata[`FLC_STAT_SUPPLY]  <= sr_q[`FLC_SR_SUPPLY_ERR];
            prdata[`FLC_STAT_PROTECT] <= sr_q[`FLC_SR_PROTECT];
            prdata[`FLC_STAT_BYTE_LO+7:`FLC_STAT_BYTE_LO] <= sr_q;
          end
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Flash pin sequencer
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= S_IDLE;
      cnt_q             <= 16'h0000;
      op_q              <= `FLC_OP_RDARRAY;
      step_q            <= 3'h0;
      sr_q              <= 8'h00;
      abort_q           <= 1'b0;
      pin_q             <= 1'b1;
      flash_addr        <= {AW{1'b0}};
      flash_dq_o        <= 8'h00;
      flash_dq_oe       <= 1'b0;
      flash_we_n        <= 1'b1;
      flash_oe_n        <= 1'b1;
      bank_enable_n     <= 1'b1;
      reset_powerdown_n <= 1'b1;
    end else begin
      pin_q <= completion_output;
      if (clr_abort) begin
        abort_q <= 1'b0;
      end
      if (go_rst) begin
        abort_q           <= busy | (clr_abort ? 1'b0 : abort_q);
        state_q           <= S_RST;
        cnt_q             <= RST_CYC;
        sr_q              <= 8'h00;
        flash_dq_oe       <= 1'b0;
        flash_we_n        <= 1'b1;
        flash_oe_n        <= 1'b1;
        bank_enable_n     <= 1'b1;
        reset_powerdown_n <= 1'b0;
      end else begin
        // Shared countdown; S_CHECK loads it, S_SETUP, S_PULSE and S_RST reload it on expiry
        if (cnt_q != 16'h0000) begin
          cnt_q <= cnt_q - 16'h0001;
        end
        case (state_q)
          S_IDLE: begin
            if (go_op) begin
              op_q    <= go_code;
              step_q  <= 3'h0;
              state_q <= S_CHECK;
            end
          end
          S_CHECK: begin
            if (cur_plan[9:8] == `FLC_KIND_WRITE) begin
              flash_addr    <= (op_q == `FLC_OP_SET) ? block_q : {AW{1'b0}};
              flash_dq_o    <= cur_plan[7:0];
              flash_dq_oe   <= 1'b1;
              bank_enable_n <= 1'b0;
              cnt_q         <= SETUP_CYC;
              state_q       <= S_SETUP;
            end else if (cur_plan[9:8] == `FLC_KIND_POLL) begin
              bank_enable_n <= 1'b0;
              flash_oe_n    <= 1'b0;
              cnt_q         <= READ_CYC;
              state_q       <= S_READ;
            end else begin
              if (op_q == `FLC_OP_CLRSTAT) begin
                sr_q <= 8'h00;
              end
              state_q <= S_IDLE;
            end
          end
          S_SETUP: begin
            if (cnt_done) begin
              flash_we_n <= 1'b0;
              cnt_q      <= WP_CYC;
              state_q    <= S_PULSE;
            end
          end
          S_PULSE: begin
            if (cnt_done) begin
              flash_we_n <= 1'b1;
              cnt_q      <= HOLD_CYC;
              state_q    <= S_HOLD;
            end
          end
          S_HOLD: begin
            if (cnt_done) begin
              flash_dq_oe   <= 1'b0;
              bank_enable_n <= 1'b1;
              step_q        <= step_q + 3'h1;
              state_q       <= S_CHECK;
            end
          end
          S_READ: begin
            if (cnt_done) begin
              flash_oe_n    <= 1'b1;
              bank_enable_n <= 1'b1;
              sr_q          <= flash_dq_i;
              if (flash_dq_i[`FLC_SR_READY]) begin
                step_q <= step_q + 3'h1;
              end
              state_q <= S_CHECK;
            end
          end
          S_RST: begin
            if (cnt_done) begin
              reset_powerdown_n <= 1'b1;
              cnt_q             <= WAKE_CYC;
              state_q           <= S_WAKE;
            end
          end
          S_WAKE: begin
            if (cnt_done) begin
              state_q <= S_IDLE;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // flc_ctrl

// ### bench/flc_ctrl_assertions.sv
/*
  Port checker for flc_ctrl, bound to every instance.
  Assumes the default parameters of the controller.
*/
`timescale 1ns/1ps
module flc_ctrl_checker #(parameter AW = 21) (
  input wire          pclk,              // Clock
  input wire          presetn,           // Reset
  input wire          psel,              // Select
  input wire          penable,           // Enable
  input wire [11:0]   paddr,             // Address
  input wire [31:0]   prdata,            // Read data
  input wire          pready,            // Ready
  input wire          pslverr,           // Error
  input wire [AW-1:0] flash_addr,        // Flash address
  input wire [7:0]    flash_dq_o,        // Flash data
  input wire          flash_dq_oe,       // Data drive
  input wire          flash_we_n,        // Write strobe
  input wire          flash_oe_n,        // Read strobe
  input wire          bank_enable_n,     // Bank enable
  input wire          reset_powerdown_n  // Flash reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_we_bank; !flash_we_n |-> !bank_enable_n && flash_dq_oe && flash_oe_n; endproperty
  property p_strobe; $fell(flash_we_n) |-> !flash_we_n [*8]; endproperty
  property p_setup; $fell(flash_we_n) |-> $past(flash_dq_oe, 2) && !$past(bank_enable_n, 2); endproperty
  property p_hold; $rose(flash_we_n) |-> flash_dq_oe && !bank_enable_n; endproperty
  property p_stable; !flash_we_n |-> $stable(flash_dq_o) && $stable(flash_addr); endproperty
  property p_poll; !flash_oe_n |-> !flash_dq_oe && !bank_enable_n; endproperty
  property p_wake; $rose(reset_powerdown_n) |-> flash_we_n [*8]; endproperty
  property p_rst_idle; !reset_powerdown_n |-> flash_we_n && flash_oe_n && !flash_dq_oe; endproperty
  property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
  property p_unmapped; psel && penable && !pready && paddr == 12'h00c |=> pslverr && prdata == 32'h0; endproperty
  a_we_bank: assert property (p_we_bank) else $error("write strobe without bank enable");
  a_strobe: assert property (p_strobe) else $error("write strobe too short");
  a_setup: assert property (p_setup) else $error("data not set up before strobe");
  a_hold: assert property (p_hold) else $error("data released with strobe");
  a_stable: assert property (p_stable) else $error("command changed under strobe");
  a_poll: assert property (p_poll) else $error("status read while driving bus");
  a_wake: assert property (p_wake) else $error("write too soon after wake");
  a_rst_idle: assert property (p_rst_idle) else $error("strobes active in power-down");
  a_ready: assert property (p_ready) else $error("bad ready timing");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  c_write: cover property ($fell(flash_we_n));
  c_refuse: cover property (pslverr);
  c_reset: cover property ($fell(reset_powerdown_n));
endmodule // flc_ctrl_checker
bind flc_ctrl flc_ctrl_checker #(.AW(AW)) chk_i (.*);

// ### bench/flc_flash_model.sv
/*
  Behavioural lock-bit flash: command latch, status byte, completion pin.
  Assumes pins change on pclk edges; completion pin pulled up outside.
*/
`timescale 1ns/1ps
module flc_flash_model (
  input  wire        pclk,              // Clock
  input  wire [20:0] flash_addr,        // Address
  input  wire [7:0]  flash_dq_o,        // Data in
  input  wire        flash_dq_oe,       // Data valid
  input  wire        flash_we_n,        // Write strobe
  input  wire        flash_oe_n,        // Read strobe
  input  wire        bank_enable_n,     // Bank enable
  input  wire        reset_powerdown_n, // Reset
  input  wire        wp_n,              // Write protect
  input  wire        vpp_ok,            // Supply good
  input  wire        seq_bad,           // Force bad sequence
  input  wire        slow,              // Long busy time
  output wire [7:0]  flash_dq_i,        // Data out
  output wire        sts_low            // Completion pulled low
);
  reg [31:0] lock_q;
  reg [8:0]  cnt_q;
  reg [7:0]  op_q, last_q;
  reg [4:0]  blk_q;
  reg        setup_q, mode_q, go_q, abort_q, we_q, sr5_q, sr4_q, sr3_q, sr1_q;
  wire       ready = cnt_q == 9'h0;
  wire [7:0] sr = {ready, 1'b0, sr5_q, sr4_q, sr3_q, 1'b0, sr1_q, 1'b0};
  wire       drive = !flash_oe_n && !bank_enable_n && reset_powerdown_n;
  wire       cmd = !we_q && flash_we_n && !bank_enable_n && flash_dq_oe;
  assign flash_dq_i = drive ? (mode_q ? sr : 8'h3c) : ~last_q;
  assign sts_low = !ready || abort_q;
  initial begin
    {lock_q, cnt_q, setup_q, mode_q, go_q, abort_q, sr5_q, sr4_q, sr3_q, sr1_q} = 0;
    last_q = 8'h0;
    we_q = 1'b1;
  end
  always @(posedge pclk) begin
    last_q <= flash_dq_i;
    we_q <= flash_we_n;
  end
  always @(posedge pclk or negedge reset_powerdown_n)
    if (!reset_powerdown_n) begin
      abort_q <= abort_q | !ready;
      {sr5_q, sr4_q, sr3_q, sr1_q, setup_q, mode_q, cnt_q} <= 0;
    end else begin
      abort_q <= 1'b0;
      if (!ready) begin
        cnt_q <= cnt_q - 9'h1;
        if (cnt_q == 9'h1 && go_q) lock_q <= (op_q == 8'h01) ? (lock_q | (32'h1 << blk_q)) : 32'h0;
      end else if (cmd && setup_q) begin
        setup_q <= 1'b0;
        mode_q <= 1'b1;
        cnt_q <= slow ? 9'h12c : 9'h3;
        op_q <= flash_dq_o;
        blk_q <= flash_addr[20:16];
        go_q <= 1'b0;
        if (seq_bad || (flash_dq_o != 8'h01 && flash_dq_o != 8'hd0)) {sr5_q, sr4_q} <= 2'b11;
        else if (!wp_n) sr1_q <= 1'b1;
        else if (!vpp_ok) begin
          sr3_q <= 1'b1;
          if (flash_dq_o == 8'h01) sr4_q <= 1'b1;
          else sr5_q <= 1'b1;
        end else go_q <= 1'b1;
      end else if (cmd && flash_dq_o == 8'h60) setup_q <= 1'b1;
      else if (cmd && flash_dq_o == 8'h50) {sr5_q, sr4_q, sr3_q, sr1_q} <= 4'h0;
      else if (cmd && flash_dq_o == 8'hff) mode_q <= 1'b0;
    end
endmodule // flc_flash_model

// ### bench/testbench.sv
/*
  Self-checking bench for flc_ctrl with the flash model.
  Assumes a short wake time; completion pin pulled up here.
*/
`timescale 1ns/1ps
module testbench;
  localparam [55:0]  CFG = 56'h21e2a4818482a4;
  localparam [223:0] EXPV = {32'h8284, 32'hb28c, 32'h4, 32'h9854, 32'h4, 32'ha864, 32'h4};
  reg         pclk, presetn, psel, penable, pwrite, wp_n, vpp_ok, seq_bad, slow, e;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, r;
  wire [31:0] prdata;
  wire        pready, pslverr, dq_oe, we_n, oe_n, be_n, rp_n, sts_low;
  wire [20:0] addr;
  wire [7:0]  dq_o, dq_i;
  integer     fail_count, total_checks, i;
  flc_ctrl #(.T_WAKE_NS(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(addr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .bank_enable_n(be_n), .reset_powerdown_n(rp_n), .completion_output(~sts_low));
  flc_flash_model fm (.pclk(pclk), .flash_addr(addr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .bank_enable_n(be_n), .reset_powerdown_n(rp_n), .wp_n(wp_n),
    .vpp_ok(vpp_ok), .seq_bad(seq_bad), .slow(slow), .flash_dq_i(dq_i), .sts_low(sts_low));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      total_checks = total_checks + 1;
      if (g !== x) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task idle;
    integer n;
    begin
      n = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && n < 300) begin
        apb(1'b0, 12'h008, 32'h0);
        n = n + 1;
      end
      chk({31'h0, r[0]}, 32'h0);
    end
  endtask
  task pin_low;
    begin
      i = 0;
      r = 32'h4;
      while (r[2] !== 1'b0 && i < 40) begin
        apb(1'b0, 12'h008, 32'h0);
        i = i + 1;
      end
    end
  endtask
  task op(input [4:0] c);
    begin
      apb(1'b1, 12'h000, {27'h0, c});
      idle;
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, 12'h008, 32'h0);
      chk(r, 32'h4);
      apb(1'b0, 12'h00c, 32'h0);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(1'b1, 12'h004, 32'h001f_0000);
      apb(1'b0, 12'h004, 32'h0);
      chk(r, 32'h001f_0000);
    end
  endtask
  task t_set_clear;
    begin
      op(5'h01);
      chk(r, 32'h8004);
      chk(fm.lock_q, 32'h8000_0000);
      chk({31'h0, fm.mode_q}, 32'h0);
      op(5'h02);
      chk(r, 32'h8004);
      chk(fm.lock_q, 32'h0);
      chk({31'h0, fm.mode_q}, 32'h0);
    end
  endtask
  task t_busy;
    begin
      slow <= 1'b1;
      apb(1'b1, 12'h000, 32'h1);
      pin_low;
      chk(r & 32'h5, 32'h1);
      apb(1'b1, 12'h000, 32'h2);
      chk({31'h0, e}, 32'h1);
      slow <= 1'b0;
      idle;
      chk(fm.lock_q, 32'h8000_0000);
    end
  endtask
  task t_errors;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        {wp_n, seq_bad, vpp_ok} <= CFG[8*(6-i)+5 +: 3];
        op(CFG[8*(6-i) +: 5]);
        chk(r, EXPV[32*(6-i) +: 32]);
      end
      chk(fm.lock_q, 32'h8000_0000);
    end
  endtask
  task t_abort;
    begin
      vpp_ok <= 1'b0;
      op(5'h01);
      {vpp_ok, slow} <= 2'b11;
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      pin_low;
      apb(1'b1, 12'h000, 32'h10);
      chk({31'h0, e}, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(r & 32'h6, 32'h2);
      slow <= 1'b0;
      idle;
      chk({31'h0, fm.mode_q}, 32'h0);
      chk(fm.lock_q, 32'h8000_0000);
      op(5'h01);
      chk(r, 32'h8006);
      chk(fm.lock_q, 32'h8000_0001);
      apb(1'b1, 12'h008, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      chk(r & 32'h2, 32'h0);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, r, e} = 0;
    {wp_n, vpp_ok, seq_bad, slow} = 4'b1100;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_set_clear;
    t_busy;
    t_errors;
    t_abort;
    end_sim;
  end
endmodule // testbench
